// *** src/sigie_parser.sv ***
// Layer 3 signalling message parser: header decode and element streaming.
// Assumes one octet per valid cycle, in order, with last on the final octet.
`timescale 1ns/1ps
// Contract
// - Call reference length is low four bits of octet two; accept 1 or 2. The code also accepts 0 and goes straight to the message type.
// - The octet after the call reference is the message type.
// - Message type bit 8 is reserved; match codes on bits 7-1.
// - Decode alerting, call proceeding, progress, setup, connect, connect acknowledge.
// - Decode user information, disconnect, restart, release, restart ack, release complete.
// - Decode facility, register, facility ack/reject, status enquiry, congestion, status.
// - Element bit 8 set means single octet; clear means variable with length.
// - Variable elements ascend in identifier within a codeset.
// - Single-octet elements may appear anywhere in the message.
// - Bits 7-5 hold type 1 identifier; pattern 010 marks type 2.
// - Spare bits sent as zero; a set spare bit never rejects.
// - Length octet counts content octets from octet three, bit 1 LSB.
// - Zero-length optional element equals absent element.
// - Content bit 8 is extension flag; one ends the group.
// - Extra extension octets are accepted and skipped without interpretation.
// - Bits 7-1 may also extend an octet; both mechanisms delimit groups. The code delimits groups on bit 8 only.
// - Network passes congestion, shift, more-data and listed variable elements.
// - Each message starts with codeset zero active.
module sigie_parser (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Octets from the link layer
    input sigie_pkg::sigie_octet_t in_oct,
    // Decoded header, one-cycle pulse
    output sigie_pkg::sigie_hdr_t hdr,
    // Element content stream
    output sigie_pkg::sigie_beat_t beat,
    // Error pulses
    output logic fmt_err,
    output logic ord_err
);
    import sigie_pkg::*;

    typedef struct packed {
        sigie_st_t st;
        logic [3:0] cr_left;
        logic [7:0] len_left;
        logic [6:0] last_id;
        logic id_seen;
        logic [2:0] codeset;
        logic [7:0] cur_id;
        logic [7:0] cur_len;
        logic [3:0] grp;
        sigie_hdr_t hdr;
        sigie_beat_t beat;
        logic fmt_err;
        logic ord_err;
    } sigie_state_t;

    sigie_state_t s_q;
    sigie_state_t s_d;
    sigie_func_t dec_func;
    logic [7:0] din;

    assign din = in_oct.data;

    sigie_msg_decode u_dec (
        .pd(s_q.hdr.pd),
        .mtype(din),
        .func(dec_func)
    );

    always_comb begin
        s_d = s_q;
        s_d.hdr.valid = 1'b0;
        s_d.beat.valid = 1'b0;
        s_d.fmt_err = 1'b0;
        s_d.ord_err = 1'b0;
        if (in_oct.valid) begin
            unique case (s_q.st)
                ST_PD: begin
                    s_d.hdr.pd = din;
                    s_d.codeset = SIGIE_CODESET_RST;
                    s_d.id_seen = 1'b0;
                    s_d.st = ST_CRLEN;
                    if (in_oct.last) begin
                        s_d.fmt_err = 1'b1;
                        s_d.st = ST_PD;
                    end
                end
                ST_CRLEN: begin
                    s_d.hdr.cr_len = din[3:0];
                    s_d.hdr.cr_flag = 1'b0;
                    s_d.hdr.cref = 15'h0000;
                    s_d.cr_left = din[3:0];
                    if (in_oct.last) begin
                        s_d.fmt_err = 1'b1;
                        s_d.st = ST_PD;
                    end else if (din[3:0] > SIGIE_CR_MAX) begin
                        s_d.fmt_err = 1'b1;
                        s_d.st = ST_DRAIN;
                    end else if (din[3:0] == 4'h0) begin
                        s_d.st = ST_MTYPE;
                    end else begin
                        s_d.st = ST_CRVAL;
                    end
                end
                ST_CRVAL: begin
                    // High octet first; flag sits in bit 8 of the first octet
                    if (s_q.cr_left == s_q.hdr.cr_len) begin
                        s_d.hdr.cr_flag = din[7];
                        s_d.hdr.cref = {8'h00, din[6:0]};
                    end else begin
                        s_d.hdr.cref = {s_q.hdr.cref[6:0], din};
                    end
                    s_d.cr_left = s_q.cr_left - 4'h1;
                    if (in_oct.last) begin
                        s_d.fmt_err = 1'b1;
                        s_d.st = ST_PD;
                    end else if (s_q.cr_left == 4'h1) begin
                        s_d.st = ST_MTYPE;
                    end
                end
                ST_MTYPE: begin
                    s_d.hdr.mtype = din;
                    s_d.hdr.func = dec_func;
                    s_d.hdr.valid = 1'b1;
                    s_d.st = in_oct.last ? ST_PD : ST_IE_ID;
                end
                ST_IE_ID: begin
                    if (din[7]) begin
                        // Accepted in any position; order tracking untouched except by an upward locking shift
                        s_d.beat.valid = 1'b1;
                        s_d.beat.first = 1'b1;
                        s_d.beat.last = 1'b1;
                        s_d.beat.single = 1'b1;
                        s_d.beat.type2 = (din[6:4] == SIGIE_TYPE2_ID);
                        s_d.beat.codeset = s_q.codeset;
                        s_d.beat.id = s_d.beat.type2 ? din : {5'h00, din[6:4]};
                        s_d.beat.len = 8'h00;
                        s_d.beat.data = din;
                        s_d.beat.grp = 4'h0;
                        s_d.beat.grp_end = 1'b1;
                        // Locking shift only moves upward; ordering restarts
                        if (din[6:4] == SIGIE_SHIFT_ID && !din[3] && din[2:0] > s_q.codeset) begin
                            s_d.codeset = din[2:0];
                            s_d.id_seen = 1'b0;
                        end
                        if (in_oct.last) begin
                            s_d.st = ST_PD;
                        end
                    end else begin
                        if (s_q.id_seen && din[6:0] <= s_q.last_id) begin
                            s_d.ord_err = 1'b1;
                        end
                        s_d.last_id = din[6:0];
                        s_d.id_seen = 1'b1;
                        s_d.cur_id = din;
                        s_d.st = ST_IE_LEN;
                        if (in_oct.last) begin
                            s_d.fmt_err = 1'b1;
                            s_d.st = ST_PD;
                        end
                    end
                end
                ST_IE_LEN: begin
                    s_d.cur_len = din;
                    s_d.len_left = din;
                    s_d.grp = 4'h0;
                    if (din == 8'h00) begin
                        // Empty element produces no beats at all
                        s_d.st = in_oct.last ? ST_PD : ST_IE_ID;
                    end else if (in_oct.last) begin
                        s_d.fmt_err = 1'b1;
                        s_d.st = ST_PD;
                    end else begin
                        s_d.st = ST_IE_BODY;
                    end
                end
                ST_IE_BODY: begin
                    // Every identifier is passed on; no element is filtered
                    s_d.beat.valid = 1'b1;
                    s_d.beat.first = (s_q.len_left == s_q.cur_len);
                    s_d.beat.last = (s_q.len_left == 8'h01) || in_oct.last;
                    s_d.beat.single = 1'b0;
                    s_d.beat.type2 = 1'b0;
                    s_d.beat.codeset = s_q.codeset;
                    s_d.beat.id = s_q.cur_id;
                    s_d.beat.len = s_q.cur_len;
                    s_d.beat.data = din;
                    // Bits 7-1 extensions stay in the group until bit 8 closes it
                    s_d.beat.grp = s_q.grp;
                    s_d.beat.grp_end = din[7];
                    s_d.grp = s_q.grp + {3'h0, din[7]};
                    s_d.len_left = s_q.len_left - 8'h01;
                    if (s_q.len_left == 8'h01) begin
                        s_d.st = in_oct.last ? ST_PD : ST_IE_ID;
                    end else if (in_oct.last) begin
                        s_d.fmt_err = 1'b1;
                        s_d.st = ST_PD;
                    end
                end
                ST_DRAIN: begin
                    if (in_oct.last) begin
                        s_d.st = ST_PD;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign hdr = s_q.hdr;
    assign beat = s_q.beat;
    assign fmt_err = s_q.fmt_err;
    assign ord_err = s_q.ord_err;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_crlen_two;
        s_q.st == ST_CRLEN && in_oct.valid && !in_oct.last && in_oct.data[3:0] == 4'h2
        |=> s_q.st == ST_CRVAL && s_q.cr_left == 4'h2 && hdr.cr_len == 4'h2;
    endproperty
    a_crlen_two: assert property (p_crlen_two) else $error("call ref length two misread");

    property p_mtype_hdr;
        s_q.st == ST_MTYPE && in_oct.valid |=> hdr.valid && hdr.mtype == $past(in_oct.data);
    endproperty
    a_mtype_hdr: assert property (p_mtype_hdr) else $error("message type not captured");

    property p_setup_bit8;
        s_q.st == ST_MTYPE && in_oct.valid && s_q.hdr.pd == SIGIE_PD_CC
        && in_oct.data[6:0] == SIGIE_MT_SETUP |=> hdr.func == FN_SETUP;
    endproperty
    a_setup_bit8: assert property (p_setup_bit8) else $error("setup code not decoded");

    property p_disc;
        s_q.st == ST_MTYPE && in_oct.valid && s_q.hdr.pd == SIGIE_PD_CC
        && in_oct.data[6:0] == SIGIE_MT_DISC |=> hdr.func == FN_DISC;
    endproperty
    a_disc: assert property (p_disc) else $error("disconnect code not decoded");

    property p_status;
        s_q.st == ST_MTYPE && in_oct.valid && s_q.hdr.pd == SIGIE_PD_CC
        && in_oct.data[6:0] == SIGIE_MT_STATUS |=> hdr.func == FN_STATUS;
    endproperty
    a_status: assert property (p_status) else $error("status code not decoded");

    property p_service;
        s_q.st == ST_MTYPE && in_oct.valid && s_q.hdr.pd == SIGIE_PD_MAINT
        && in_oct.data[6:0] == SIGIE_MT_SERVICE |=> hdr.func == FN_SERVICE;
    endproperty
    a_service: assert property (p_service) else $error("service not told from connect ack");

    property p_single_fmt;
        s_q.st == ST_IE_ID && in_oct.valid && in_oct.data[7]
        |=> beat.valid && beat.single && beat.data == $past(in_oct.data);
    endproperty
    a_single_fmt: assert property (p_single_fmt) else $error("single octet element lost");

    property p_type2;
        beat.valid && beat.single |-> beat.type2 == (beat.data[6:4] == SIGIE_TYPE2_ID);
    endproperty
    a_type2: assert property (p_type2) else $error("type 2 flag wrong");

    property p_order;
        s_q.st == ST_IE_ID && in_oct.valid && !in_oct.data[7] && s_q.id_seen
        && in_oct.data[6:0] <= s_q.last_id |=> ord_err;
    endproperty
    a_order: assert property (p_order) else $error("descending identifier not flagged");

    property p_empty;
        s_q.st == ST_IE_LEN && in_oct.valid && in_oct.data == 8'h00 |=> !beat.valid;
    endproperty
    a_empty: assert property (p_empty) else $error("empty element produced a beat");

    property p_codeset0;
        hdr.valid |-> s_q.codeset == SIGIE_CODESET_RST;
    endproperty
    a_codeset0: assert property (p_codeset0) else $error("codeset not zero at message start");

    property p_overrun;
        s_q.st == ST_IE_BODY && in_oct.valid && in_oct.last && s_q.len_left > 8'h01
        |=> fmt_err && beat.last && s_q.st == ST_PD;
    endproperty
    a_overrun: assert property (p_overrun) else $error("length overrun not flagged");

    c_setup: cover property (hdr.valid && hdr.func == FN_SETUP);
    c_elem_end: cover property (beat.valid && beat.last && !beat.single);
    c_fmt: cover property (fmt_err);
    c_order: cover property (ord_err);

endmodule // sigie_parser

// *** src/sigie_pkg.sv ***
// Constants, types and carriers for the signalling message and element parser.
// Assumes one clock domain and octets delivered in order by the link layer.
package sigie_pkg;

    // Protocol discriminators
    localparam logic [7:0] SIGIE_PD_MAINT = 8'h03;
    localparam logic [7:0] SIGIE_PD_CC = 8'h08;

    // Call reference
    localparam logic [3:0] SIGIE_CR_MAX = 4'h2;

    // Single-octet element identifiers (bits 7-5) and the reset codeset
    localparam logic [2:0] SIGIE_TYPE2_ID = 3'h2;
    localparam logic [2:0] SIGIE_SHIFT_ID = 3'h1;
    localparam logic [2:0] SIGIE_CODESET_RST = 3'h0;

    // Message type codes, bit 8 excluded
    localparam logic [6:0] SIGIE_MT_ALERT = 7'h01;
    localparam logic [6:0] SIGIE_MT_CALLPROC = 7'h02;
    localparam logic [6:0] SIGIE_MT_PROGRESS = 7'h03;
    localparam logic [6:0] SIGIE_MT_SETUP = 7'h05;
    localparam logic [6:0] SIGIE_MT_CONNECT = 7'h07;
    localparam logic [6:0] SIGIE_MT_CONNACK = 7'h0f;
    localparam logic [6:0] SIGIE_MT_USERINFO = 7'h20;
    localparam logic [6:0] SIGIE_MT_DISC = 7'h45;
    localparam logic [6:0] SIGIE_MT_RESTART = 7'h46;
    localparam logic [6:0] SIGIE_MT_RELEASE = 7'h4d;
    localparam logic [6:0] SIGIE_MT_RESTACK = 7'h4e;
    localparam logic [6:0] SIGIE_MT_RELCOMP = 7'h5a;
    localparam logic [6:0] SIGIE_MT_FAC = 7'h62;
    localparam logic [6:0] SIGIE_MT_REGISTER = 7'h64;
    localparam logic [6:0] SIGIE_MT_FACACK = 7'h6a;
    localparam logic [6:0] SIGIE_MT_FACREJ = 7'h72;
    localparam logic [6:0] SIGIE_MT_STATENQ = 7'h75;
    localparam logic [6:0] SIGIE_MT_CONGEST = 7'h79;
    localparam logic [6:0] SIGIE_MT_STATUS = 7'h7d;
    localparam logic [6:0] SIGIE_MT_SERVICE = 7'h0f;
    localparam logic [6:0] SIGIE_MT_SERVACK = 7'h07;

    typedef enum logic [4:0] {
        FN_UNKNOWN = 5'h00, FN_ALERT = 5'h01, FN_CALLPROC = 5'h02, FN_PROGRESS = 5'h03,
        FN_SETUP = 5'h04, FN_CONNECT = 5'h05, FN_CONNACK = 5'h06, FN_USERINFO = 5'h07,
        FN_DISC = 5'h08, FN_RESTART = 5'h09, FN_RELEASE = 5'h0a, FN_RESTACK = 5'h0b,
        FN_RELCOMP = 5'h0c, FN_FAC = 5'h0d, FN_REGISTER = 5'h0e, FN_FACACK = 5'h0f,
        FN_FACREJ = 5'h10, FN_STATENQ = 5'h11, FN_CONGEST = 5'h12, FN_STATUS = 5'h13,
        FN_SERVICE = 5'h14, FN_SERVACK = 5'h15
    } sigie_func_t;

    typedef enum logic [2:0] {
        ST_PD = 3'h0, ST_CRLEN = 3'h1, ST_CRVAL = 3'h2, ST_MTYPE = 3'h3,
        ST_IE_ID = 3'h4, ST_IE_LEN = 3'h5, ST_IE_BODY = 3'h6, ST_DRAIN = 3'h7
    } sigie_st_t;

    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } sigie_octet_t;

    typedef struct packed {
        logic valid;
        logic [7:0] pd;
        logic [3:0] cr_len;
        logic cr_flag;
        logic [14:0] cref;
        logic [7:0] mtype;
        sigie_func_t func;
    } sigie_hdr_t;

    typedef struct packed {
        logic valid;
        logic first;
        logic last;
        logic single;
        logic type2;
        logic [2:0] codeset;
        logic [7:0] id;
        logic [7:0] len;
        logic [7:0] data;
        logic [3:0] grp;
        logic grp_end;
    } sigie_beat_t;

endpackage

// *** src/sigie_msg_decode.sv ***
// Message type decoder: discriminator plus type octet to message function.
// Purely combinational; the parser registers the result.
`timescale 1ns/1ps
module sigie_msg_decode (
    // Message header fields
    input wire logic [7:0] pd,
    input wire logic [7:0] mtype,
    // Decoded function
    output sigie_pkg::sigie_func_t func
);
    import sigie_pkg::*;

    always_comb begin
        func = FN_UNKNOWN;
        // Bit 8 reserved; codes matched on bits 7-1 only
        if (pd == SIGIE_PD_MAINT) begin
            case (mtype[6:0])
                SIGIE_MT_SERVICE: func = FN_SERVICE;
                SIGIE_MT_SERVACK: func = FN_SERVACK;
                default: func = FN_UNKNOWN;
            endcase
        end else if (pd == SIGIE_PD_CC) begin
            case (mtype[6:0])
                SIGIE_MT_ALERT: func = FN_ALERT;
                SIGIE_MT_CALLPROC: func = FN_CALLPROC;
                SIGIE_MT_PROGRESS: func = FN_PROGRESS;
                SIGIE_MT_SETUP: func = FN_SETUP;
                SIGIE_MT_CONNECT: func = FN_CONNECT;
                SIGIE_MT_CONNACK: func = FN_CONNACK;
                SIGIE_MT_USERINFO: func = FN_USERINFO;
                SIGIE_MT_DISC: func = FN_DISC;
                SIGIE_MT_RESTART: func = FN_RESTART;
                SIGIE_MT_RELEASE: func = FN_RELEASE;
                SIGIE_MT_RESTACK: func = FN_RESTACK;
                SIGIE_MT_RELCOMP: func = FN_RELCOMP;
                SIGIE_MT_FAC: func = FN_FAC;
                SIGIE_MT_REGISTER: func = FN_REGISTER;
                SIGIE_MT_FACACK: func = FN_FACACK;
                SIGIE_MT_FACREJ: func = FN_FACREJ;
                SIGIE_MT_STATENQ: func = FN_STATENQ;
                SIGIE_MT_CONGEST: func = FN_CONGEST;
                SIGIE_MT_STATUS: func = FN_STATUS;
                default: func = FN_UNKNOWN;
            endcase
        end
    end

endmodule // sigie_msg_decode

// *** verif/sigie_cpe_model.sv ***
// Customer equipment model: feeds signalling octets to the parser.
// Assumes the bench seeds the generator and calls the tasks from one process.
`timescale 1ns/1ps
module sigie_cpe_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Octets towards the parser
    output sigie_pkg::sigie_octet_t oct
);
    import sigie_pkg::*;

    initial oct = '0;

    // Idle line toggles data so a stale octet never looks valid
    task automatic idle();
        @(posedge ref_clk);
        #1;
        oct.valid = 1'b0;
        oct.last = 1'b0;
        oct.data = ~oct.data;
    endtask

    // Elements go out in builder order, which is descending in the element order test
    task automatic send_msg(input logic [7:0] msg[$], input bit gaps);
        for (int i = 0; i < msg.size(); i++) begin
            while (gaps && ($urandom % 4 == 0)) begin
                idle();
            end
            @(posedge ref_clk);
            #1;
            oct.valid = 1'b1;
            oct.last = (i == msg.size() - 1);
            oct.data = msg[i];
        end
    endtask
endmodule // sigie_cpe_model

// *** verif/sigie_parser_tb.sv ***
// Self-checking bench for the signalling parser against a queue model.
// Assumes the parser and the customer equipment model are compiled first.
`timescale 1ns/1ps
module sigie_parser_tb;
    import sigie_pkg::*;
    logic ref_clk;
    logic rst;
    sigie_octet_t in_oct;
    sigie_hdr_t hdr;
    sigie_beat_t beat;
    logic fmt_err;
    logic ord_err;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int fmt_seen = 0, fmt_exp = 0, ord_seen = 0, ord_exp = 0;
    logic [63:0] hdr_seen[$], hdr_exp[$], beat_seen[$], beat_exp[$];
    logic [7:0] msg[$];
    // Discriminator and code, in function order
    logic [15:0] codes [0:20] = '{16'h0801, 16'h0802, 16'h0803, 16'h0805, 16'h0807,
        16'h080f, 16'h0820, 16'h0845, 16'h0846, 16'h084d, 16'h084e, 16'h085a,
        16'h0862, 16'h0864, 16'h086a, 16'h0872, 16'h0875, 16'h0879, 16'h087d,
        16'h030f, 16'h0307};

    sigie_parser sigie_parser_i (.ref_clk(ref_clk), .rst(rst), .in_oct(in_oct),
        .hdr(hdr), .beat(beat), .fmt_err(fmt_err), .ord_err(ord_err));
    sigie_cpe_model sigie_cpe_model_i (.ref_clk(ref_clk), .rst(rst), .oct(in_oct));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    function automatic logic [63:0] pack_beat(input sigie_beat_t b);
        return {28'h0, b.grp, b.first, b.last, b.single, b.type2, b.codeset, b.id, b.len,
            b.data, b.grp_end};
    endfunction

    always @(posedge ref_clk) begin
        cycles++;
        if (rst === 1'b0) begin
            if (hdr.valid === 1'b1) hdr_seen.push_back(64'(hdr));
            if (beat.valid === 1'b1) beat_seen.push_back(pack_beat(beat));
            if (fmt_err === 1'b1) fmt_seen++;
            if (ord_err === 1'b1) ord_seen++;
        end
        if (cycles > 20000) begin
            num_errors++;
            conclude();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic add_var(input logic [7:0] id);
        int len;
        len = $urandom % 4;
        msg.push_back(id);
        msg.push_back(8'(len));
        repeat (len) msg.push_back(8'($urandom));
    endtask

    // Random single element first, type 2 single last; spare bits of octet two random
    task automatic build(input logic [7:0] pd, input logic [7:0] mt, input int crl,
        input logic [7:0] id_a, input logic [7:0] id_b);
        msg = {};
        msg.push_back(pd);
        msg.push_back({4'($urandom), 4'(crl)});
        repeat (crl) msg.push_back(8'($urandom));
        msg.push_back(mt);
        // Any single element with bits 7-5 nonzero, shifts included
        msg.push_back({1'b1, 3'(1 + $urandom % 7), 4'($urandom)});
        add_var(id_a);
        add_var(id_b);
        msg.push_back({4'ha, 4'($urandom)});
    endtask

    task automatic predict();
        sigie_hdr_t h;
        sigie_beat_t b;
        int crl, i, len, avail;
        logic [7:0] prev, o;
        logic [2:0] cs;
        logic [3:0] grp;
        bit seen;
        crl = msg[1][3:0];
        if (crl > 2) begin
            fmt_exp++;
            return;
        end
        h = '0;
        h.valid = 1'b1;
        h.pd = msg[0];
        h.cr_len = msg[1][3:0];
        h.cr_flag = msg[2][7];
        h.cref = (crl == 1) ? 15'(msg[2][6:0]) : {msg[2][6:0], msg[3]};
        h.mtype = msg[2 + crl];
        for (int k = 0; k < 21; k++) begin
            if (codes[k][15:8] == h.pd && codes[k][6:0] == h.mtype[6:0] && h.func == FN_UNKNOWN)
                h.func = sigie_func_t'(k + 1);
        end
        hdr_exp.push_back(64'(h));
        prev = 8'h00;
        cs = 3'h0;
        seen = 1'b0;
        i = 3 + crl;
        while (i < msg.size()) begin
            o = msg[i];
            b = '0;
            b.id = o;
            b.data = o;
            b.first = 1'b1;
            b.last = 1'b1;
            b.codeset = cs;
            if (o[7]) begin
                b.single = 1'b1;
                b.type2 = (o[6:4] == 3'h2);
                if (!b.type2) b.id = {5'h00, o[6:4]};
                b.grp_end = 1'b1;
                beat_exp.push_back(pack_beat(b));
                // Locking shift moves only upward and restarts ordering
                if (o[6:4] == SIGIE_SHIFT_ID && !o[3] && o[2:0] > cs) begin
                    cs = o[2:0];
                    seen = 1'b0;
                end
                i++;
            end else if (i + 1 >= msg.size()) begin
                fmt_exp++;
                break;
            end else begin
                len = msg[i + 1];
                avail = (len < msg.size() - i - 2) ? len : msg.size() - i - 2;
                if (seen && o <= prev) ord_exp++;
                prev = o;
                seen = 1'b1;
                grp = 4'h0;
                b.len = 8'(len);
                for (int k = 0; k < avail; k++) begin
                    b.first = (k == 0);
                    b.last = (k == avail - 1);
                    b.data = msg[i + 2 + k];
                    b.grp_end = b.data[7];
                    b.grp = grp;
                    grp = grp + {3'h0, b.data[7]};
                    beat_exp.push_back(pack_beat(b));
                end
                if (len > avail) begin
                    fmt_exp++;
                    break;
                end
                i += 2 + len;
            end
        end
    endtask

    task automatic run(input bit gaps);
        predict();
        sigie_cpe_model_i.send_msg(msg, gaps);
    endtask

    task automatic compare_all(input bit beats, input string name);
        sigie_cpe_model_i.idle();
        repeat (4) @(posedge ref_clk);
        check(64'(hdr_seen.size()), 64'(hdr_exp.size()), "header count");
        for (int i = 0; i < hdr_exp.size() && i < hdr_seen.size(); i++)
            check(hdr_seen[i], hdr_exp[i], "header");
        if (beats) begin
            check(64'(beat_seen.size()), 64'(beat_exp.size()), "beat count");
            for (int i = 0; i < beat_exp.size() && i < beat_seen.size(); i++)
                check(beat_seen[i], beat_exp[i], "beat");
        end
        check(64'(fmt_seen), 64'(fmt_exp), "format errors");
        check(64'(ord_seen), 64'(ord_exp), "order errors");
        hdr_seen = {};
        hdr_exp = {};
        beat_seen = {};
        beat_exp = {};
        fmt_seen = 0;
        fmt_exp = 0;
        ord_seen = 0;
        ord_exp = 0;
        $display("Test %s done", name);
    endtask

    initial begin
        logic [7:0] id_a;
        rst = 1'b1;
        void'($urandom(32'hf689b4be));
        repeat (16) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        for (int i = 0; i < 21; i++) begin
            build(codes[i][15:8], codes[i][7:0], 1 + i % 2, 8'h04, 8'h18);
            run(i % 3 == 0);
        end
        compare_all(1'b1, "message functions");
        // Reserved top bit, unknown code, call code under maintenance discriminator
        build(8'h08, 8'h85, 2, 8'h08, 8'h1e);
        run(1'b0);
        build(8'h08, 8'h7f, 1, 8'h04, 8'h6c);
        run(1'b0);
        build(8'h03, 8'h05, 1, 8'h04, 8'h18);
        run(1'b0);
        compare_all(1'b1, "type octet corners");
        // Descending identifiers; beat behaviour after the flag is left open
        build(8'h08, 8'h05, 1, 8'h18, 8'h04);
        run(1'b1);
        compare_all(1'b0, "element order");
        // Call reference of three octets, then a message that follows it
        msg = {8'h08, 8'h03, 8'h00, 8'h00, 8'h00, 8'h05, 8'h04};
        run(1'b0);
        msg = {8'h08, 8'h01, 8'h05, 8'h05, 8'h04, 8'h05, 8'h81, 8'h02};
        run(1'b0);
        compare_all(1'b1, "header and length overrun");
        repeat (30) begin
            id_a = 8'(1 + $urandom % 60);
            build(8'h08, 8'($urandom), 1 + $urandom % 2, id_a, 8'(id_a + 1 + $urandom % 60));
            run($urandom % 2 == 0);
        end
        compare_all(1'b1, "random messages");
        conclude();
    end
endmodule // sigie_parser_tb
